//--- core/sad_regs.vh
// Purpose: Address map constants for the secure alias address decoder.
// Assumes: 32-bit byte addresses.
// Notes: Ranges are given as non-secure aliases; the secure alias sets bit 28.
`ifndef SAD_REGS_VH
`define SAD_REGS_VH
`define SAD_SEC_BIT 28
`define SAD_CODE_NS_BASE 32'h00000000
`define SAD_CODE_S_BASE 32'h10000000
`define SAD_SRAM_NS_BASE 32'h20000000
`define SAD_SRAM_S_BASE 32'h30000000
`define SAD_PERI_NS_BASE 32'h40000000
`define SAD_PERI_S_BASE 32'h50000000
`define SAD_FLASH_LO 32'h00000000
`define SAD_FLASH_HI 32'h0009FFFF
`define SAD_ROM_LO 32'h03000000
`define SAD_ROM_HI 32'h0301FFFF
`define SAD_SRAMX_LO 32'h04000000
`define SAD_SRAMX_HI 32'h04007FFF
`define SAD_SRAMD_LO 32'h20000000
`define SAD_SRAMD_HI 32'h20043FFF
`define SAD_APB_LO 32'h40000000
`define SAD_APB_HI 32'h4003FFFF
`define SAD_AHBP0_LO 32'h40080000
`define SAD_AHBP0_HI 32'h400AFFFF
`define SAD_AHBP1_LO 32'h40100000
`define SAD_AHBP1_HI 32'h4010FFFF
`define SAD_TGT_FLASH 3'h0
`define SAD_TGT_ROM 3'h1
`define SAD_TGT_SRAMX 3'h2
`define SAD_TGT_SRAMD 3'h3
`define SAD_TGT_APB 3'h4
`define SAD_TGT_AHBP 3'h5
`define SAD_TGT_NONE 3'h7
`define SAD_ATTR_NS 2'h0
`define SAD_ATTR_S 2'h1
`define SAD_ATTR_NSC 2'h2
`endif

//--- core/sad_port_decode.v
// Purpose: Window compare for one matrix slave port.
// Assumes: The address reaching it already has the alias bit cleared.
// Notes: Pure logic; the caller registers whatever it picks from here.
`timescale 1ns/1ns
`default_nettype none
module sad_port_decode #(
    parameter [31:0] RANGE_LO = 32'h00000000,
    parameter [31:0] RANGE_HI = 32'h00000000,
    parameter [31:0] RANGE_BASE = 32'h00000000
) (
    input wire [31:0] phys_addr,
    output wire hit,
    output wire [31:0] offset
);
    assign hit = (phys_addr >= RANGE_LO) && (phys_addr <= RANGE_HI);
    // The offset is formed even on a miss, since a window that is not picked is ignored.
    assign offset = phys_addr - RANGE_BASE;
endmodule // sad_port_decode
`default_nettype wire

//--- core/sad_decoder.v
// Purpose: Per-master address decode and security attribution for the bus matrix.
// Assumes: All request signals are from logic on sys_clk.
// Notes: One independent decode slice per master; arbitration lives elsewhere.
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.vh"
module sad_decoder #(
    parameter NUM_MASTERS = 2,
    parameter NSC_LO = 32'h1000FC00,
    parameter NSC_HI = 32'h1000FFFF
) (
    input wire sys_clk,
    input wire resetn,
    input wire [NUM_MASTERS-1:0] req_valid,
    input wire [NUM_MASTERS*32-1:0] req_addr,
    input wire [NUM_MASTERS-1:0] req_secure_master,
    input wire [NUM_MASTERS-1:0] chk_grant_secure,
    output wire [NUM_MASTERS-1:0] sel_valid,
    output wire [NUM_MASTERS*3-1:0] sel_target,
    output wire [NUM_MASTERS*32-1:0] sel_offset,
    output wire [NUM_MASTERS*2-1:0] sel_attr,
    output wire [NUM_MASTERS-1:0] sel_code_bus,
    output wire [NUM_MASTERS-1:0] sel_error,
    output wire [NUM_MASTERS-1:0] sel_sec_denied
);
    // Range slots, one per matrix slave window.
    localparam RG_FLASH = 0;
    localparam RG_ROM = 1;
    localparam RG_SRAMX = 2;
    localparam RG_SRAMD = 3;
    localparam RG_APB = 4;
    localparam RG_AHBP0 = 5;
    localparam RG_AHBP1 = 6;
    localparam N_RANGES = 7;

    // Master 0 is the primary core; the rest lack their own security extension.
    // Each slice is private, so no master ever waits on another's decode.
    genvar i;
    generate
        for (i = 0; i < NUM_MASTERS; i = i + 1) begin : g_port
            wire [31:0] addr;
            wire [31:0] phys;
            wire is_sec;
            wire is_primary;
            wire sec_ok;
            wire in_nsc;
            wire mapped;
            wire [N_RANGES-1:0] hit;
            wire [N_RANGES*32-1:0] offs;
            reg [2:0] next_target;
            reg [31:0] next_offset;
            reg [1:0] next_attr;
            reg next_valid;
            reg next_code_bus;
            reg next_error;
            reg next_denied;
            reg valid;
            reg [2:0] target;
            reg [31:0] offset;
            reg [1:0] attr;
            reg code_bus;
            reg error;
            reg denied;

            assign addr = req_addr[i*32 +: 32];
            assign is_sec = addr[`SAD_SEC_BIT];
            // Clearing bit 28 before the compare makes both aliases hit one window.
            assign phys = addr & ~(32'h00000001 << `SAD_SEC_BIT);
            assign is_primary = (i == 0);
            // The checker's verdict is taken as given; no permission is judged here.
            assign sec_ok = is_primary | (req_secure_master[i] & chk_grant_secure[i]);
            assign in_nsc = (addr >= NSC_LO) && (addr <= NSC_HI);

            sad_port_decode #(
                .RANGE_LO(`SAD_FLASH_LO),
                .RANGE_HI(`SAD_FLASH_HI),
                .RANGE_BASE(`SAD_FLASH_LO)
            ) u_flash (
                .phys_addr(phys),
                .hit(hit[RG_FLASH]),
                .offset(offs[RG_FLASH*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_ROM_LO),
                .RANGE_HI(`SAD_ROM_HI),
                .RANGE_BASE(`SAD_ROM_LO)
            ) u_rom (
                .phys_addr(phys),
                .hit(hit[RG_ROM]),
                .offset(offs[RG_ROM*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_SRAMX_LO),
                .RANGE_HI(`SAD_SRAMX_HI),
                .RANGE_BASE(`SAD_SRAMX_LO)
            ) u_sramx (
                .phys_addr(phys),
                .hit(hit[RG_SRAMX]),
                .offset(offs[RG_SRAMX*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_SRAMD_LO),
                .RANGE_HI(`SAD_SRAMD_HI),
                .RANGE_BASE(`SAD_SRAMD_LO)
            ) u_sramd (
                .phys_addr(phys),
                .hit(hit[RG_SRAMD]),
                .offset(offs[RG_SRAMD*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_APB_LO),
                .RANGE_HI(`SAD_APB_HI),
                .RANGE_BASE(`SAD_APB_LO)
            ) u_apb (
                .phys_addr(phys),
                .hit(hit[RG_APB]),
                .offset(offs[RG_APB*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_AHBP0_LO),
                .RANGE_HI(`SAD_AHBP0_HI),
                .RANGE_BASE(`SAD_PERI_NS_BASE)
            ) u_ahbp0 (
                .phys_addr(phys),
                .hit(hit[RG_AHBP0]),
                .offset(offs[RG_AHBP0*32 +: 32])
            );

            sad_port_decode #(
                .RANGE_LO(`SAD_AHBP1_LO),
                .RANGE_HI(`SAD_AHBP1_HI),
                .RANGE_BASE(`SAD_PERI_NS_BASE)
            ) u_ahbp1 (
                .phys_addr(phys),
                .hit(hit[RG_AHBP1]),
                .offset(offs[RG_AHBP1*32 +: 32])
            );

            always @* begin
                next_target = `SAD_TGT_NONE;
                next_offset = 32'h00000000;
                if (hit[RG_FLASH]) begin
                    next_target = `SAD_TGT_FLASH;
                    next_offset = offs[RG_FLASH*32 +: 32];
                end else if (hit[RG_ROM]) begin
                    next_target = `SAD_TGT_ROM;
                    next_offset = offs[RG_ROM*32 +: 32];
                end else if (hit[RG_SRAMX]) begin
                    next_target = `SAD_TGT_SRAMX;
                    next_offset = offs[RG_SRAMX*32 +: 32];
                end else if (hit[RG_SRAMD]) begin
                    next_target = `SAD_TGT_SRAMD;
                    next_offset = offs[RG_SRAMD*32 +: 32];
                end else if (hit[RG_APB]) begin
                    next_target = `SAD_TGT_APB;
                    next_offset = offs[RG_APB*32 +: 32];
                end else if (hit[RG_AHBP0] || hit[RG_AHBP1]) begin
                    next_target = `SAD_TGT_AHBP;
                    next_offset = hit[RG_AHBP0] ? offs[RG_AHBP0*32 +: 32] : offs[RG_AHBP1*32 +: 32];
                end
            end

            always @* begin
                if (!is_sec) begin
                    next_attr = `SAD_ATTR_NS;
                end else if (in_nsc) begin
                    next_attr = `SAD_ATTR_NSC;
                end else begin
                    next_attr = `SAD_ATTR_S;
                end
            end

            assign mapped = (next_target != `SAD_TGT_NONE);

            always @* begin
                next_valid = req_valid[i] && mapped && (!is_sec || sec_ok);
                next_error = req_valid[i] && !mapped;
                next_denied = req_valid[i] && mapped && is_sec && !sec_ok;
                next_code_bus = (addr < `SAD_SRAM_NS_BASE);
            end

            always @(posedge sys_clk) begin
                if (!resetn) begin
                    valid <= 1'b0;
                    target <= `SAD_TGT_NONE;
                    offset <= 32'h00000000;
                    attr <= `SAD_ATTR_NS;
                    code_bus <= 1'b0;
                    error <= 1'b0;
                    denied <= 1'b0;
                end else begin
                    valid <= next_valid;
                    target <= next_target;
                    offset <= next_offset;
                    attr <= next_attr;
                    code_bus <= next_code_bus;
                    error <= next_error;
                    denied <= next_denied;
                end
            end

            assign sel_valid[i] = valid;
            assign sel_target[i*3 +: 3] = target;
            assign sel_offset[i*32 +: 32] = offset;
            assign sel_attr[i*2 +: 2] = attr;
            assign sel_code_bus[i] = code_bus;
            assign sel_error[i] = error;
            assign sel_sec_denied[i] = denied;
        end
    endgenerate
endmodule // sad_decoder
`default_nettype wire

//--- verification/sad_chk.sv
// Purpose: Port checks for the alias decoder.
// Assumes: Master 0 is the primary core, two masters.
// Notes: Each answer lands one cycle after its request.
`timescale 1ns/1ns
`default_nettype none
module sad_chk #(parameter NUM_MASTERS = 2, NSC_LO = 32'h1000FC00, NSC_HI = 32'h1000FFFF) (
    input wire sys_clk,
    input wire resetn,
    input wire [NUM_MASTERS-1:0] req_valid,
    input wire [NUM_MASTERS*32-1:0] req_addr,
    input wire [NUM_MASTERS-1:0] req_secure_master,
    input wire [NUM_MASTERS-1:0] chk_grant_secure,
    input wire [NUM_MASTERS-1:0] sel_valid,
    input wire [NUM_MASTERS*3-1:0] sel_target,
    input wire [NUM_MASTERS*2-1:0] sel_attr,
    input wire [NUM_MASTERS-1:0] sel_code_bus,
    input wire [NUM_MASTERS-1:0] sel_error,
    input wire [NUM_MASTERS-1:0] sel_sec_denied
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire [31:0] a0 = req_addr[31:0];
    wire [31:0] n0 = a0 & 32'hEFFFFFFF;
    sequence s_sram; req_valid[0] && n0 >= 32'h20000000 && n0 <= 32'h20043FFF; endsequence
    sequence s_alias; &req_valid[1:0] && (a0 ^ req_addr[63:32]) == 32'h10000000; endsequence
    chk_ns_attr: assert property (req_valid[0] && !a0[28] |=> sel_attr[1:0] == 2'h0)
        else $error("attr not non-secure");
    chk_sec_attr: assert property (req_valid[0] && a0[28] |=> sel_attr[1:0] != 2'h0)
        else $error("attr not secure");
    chk_alias_same: assert property (s_alias |=> sel_target[2:0] == sel_target[5:3])
        else $error("aliases pick different targets");
    chk_sram_sel: assert property (s_sram |=> sel_valid[0] && sel_target[2:0] == 3'h3)
        else $error("data sram not selected");
    chk_code_port: assert property (req_valid[0] |=> sel_code_bus[0] == ($past(a0) < 32'h20000000))
        else $error("wrong bus port");
    chk_nsc_attr: assert property (req_valid[0] && a0 >= NSC_LO && a0 <= NSC_HI |=> sel_attr[1:0] == 2'h2)
        else $error("callable area not marked");
    chk_err_none: assert property (sel_error[0] |-> !sel_valid[0] && sel_target[2:0] == 3'h7)
        else $error("error with a target");
    chk_sec_master: assert property (req_valid[1] && req_secure_master[1] &&
        chk_grant_secure[1] |=> !sel_sec_denied[1]) else $error("secure master denied");
    chk_deny_plain: assert property (req_valid[1] && req_addr[60] &&
        !(req_secure_master[1] && chk_grant_secure[1])
        |=> !sel_valid[1] && sel_sec_denied[1] == (sel_target[5:3] != 3'h7))
        else $error("plain secondary not denied");
    chk_peri_sec: assert property (req_valid[0] && a0[31:28] == 4'h5 &&
        n0 <= 32'h4003FFFF |=> sel_target[2:0] == 3'h4) else $error("secure bridge alias missed");
endmodule // sad_chk
bind sad_decoder sad_chk #(.NUM_MASTERS(NUM_MASTERS), .NSC_LO(NSC_LO), .NSC_HI(NSC_HI)) chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req_addr(req_addr),
    .req_secure_master(req_secure_master), .chk_grant_secure(chk_grant_secure),
    .sel_valid(sel_valid), .sel_target(sel_target), .sel_attr(sel_attr),
    .sel_code_bus(sel_code_bus), .sel_error(sel_error), .sel_sec_denied(sel_sec_denied));
`default_nettype wire

//--- verification/sad_master_model.sv
// Purpose: Second bus master forming addresses.
// Assumes: Bases are non-secure aliases.
// Notes: Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module sad_master_model (
    input wire logic [31:0] base,
    input wire logic want_sec,
    output logic [31:0] addr);
    assign addr = base | {3'h0, want_sec, 28'h0};
endmodule // sad_master_model
`default_nettype wire

//--- verification/tb_secure_alias_address_decoder.sv
// Purpose: Random decode test of both masters.
// Assumes: Master 0 is the primary core.
// Notes: One note per request, checked one cycle on.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_secure_alias_address_decoder;
    logic sys_clk = 0, resetn = 0, s1 = 0;
    logic [1:0] req_valid = 0, req_secure_master = 0, chk_grant_secure = 0;
    logic [31:0] a0 = 0, base1 = 0, r;
    wire [31:0] addr1;
    wire [63:0] req_addr = {addr1, a0};
    wire [1:0] sel_valid, sel_error, sel_sec_denied, sel_code_bus;
    wire [5:0] sel_target;
    wire [3:0] sel_attr;
    wire [63:0] sel_offset;
    wire [40:0] seen0 = {sel_error[0], sel_valid[0], sel_sec_denied[0], sel_target[2:0],
        sel_attr[1:0], sel_code_bus[0], sel_offset[31:0]};
    wire [40:0] seen1 = {sel_error[1], sel_valid[1], sel_sec_denied[1], sel_target[5:3],
        sel_attr[3:2], sel_code_bus[1], sel_offset[63:32]};
    logic [81:0] q[$], e;
    integer seed = 32'h8469, n_errors = 0, compares = 0, cyc = 0, i;
    logic [31:0] lo [0:8] = '{32'h0, 32'h3000000, 32'h4000000, 32'h20000000, 32'h40000000,
        32'h40080000, 32'h40100000, 32'h20050000, 32'h1000FC00};
    logic [31:0] hi [0:6] = '{32'h9FFFF, 32'h301FFFF, 32'h4007FFF, 32'h20043FFF, 32'h4003FFFF,
        32'h400AFFFF, 32'h4010FFFF};
    sad_decoder dut_u (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
        .req_addr(req_addr), .req_secure_master(req_secure_master),
        .chk_grant_secure(chk_grant_secure), .sel_valid(sel_valid), .sel_target(sel_target),
        .sel_offset(sel_offset), .sel_attr(sel_attr), .sel_code_bus(sel_code_bus),
        .sel_error(sel_error),
        .sel_sec_denied(sel_sec_denied));
    sad_master_model mm_u (.base(base1), .want_sec(s1), .addr(addr1));
    function automatic logic [2:0] tgt_of(input logic [31:0] x);
        int k;
        tgt_of = 3'h7;
        for (k = 0; k < 7; k++) if ((x & 32'hEFFFFFFF) >= lo[k] && (x & 32'hEFFFFFFF) <= hi[k])
            tgt_of = (k > 5) ? 3'h5 : k[2:0];
    endfunction
    function automatic logic [31:0] off_of(input logic [31:0] x);
        logic [2:0] t;
        t = tgt_of(x);
        off_of = (t == 3'h7) ? 32'h0 : (x & 32'hEFFFFFFF) - ((t == 3'h5) ? 32'h40000000 : lo[t]);
    endfunction
    function automatic logic [40:0] note_of(input logic [31:0] x, input logic prim, ok);
        logic [2:0] t;
        logic den;
        t = tgt_of(x);
        den = !prim && t != 3'h7 && x[28] && !ok;
        return {t == 3'h7, t != 3'h7 && !den, den, t, x[28] ? ((x >= 32'h1000FC00 &&
            x <= 32'h1000FFFF) ? 2'h2 : 2'h1) : 2'h0, x < 32'h20000000, off_of(x)};
    endfunction
    task stop_test;
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        repeat (2) @(negedge sys_clk);
        resetn = 1;
        for (i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            r = $random(seed);
            a0 = lo[r[7:0] % 9] | r[19:8];
            a0[28] = a0[28] ^ r[20];
            base1 = r[21] ? (a0 & 32'hEFFFFFFF) : lo[r[27:24] % 9];
            s1 = r[21] ? !a0[28] : r[22];
            {req_valid, req_secure_master, chk_grant_secure} = {2'h3, r[23], r[29], r[28], r[30]};
            #1 q.push_back({note_of(addr1, 1'b0, r[23] && r[28]), note_of(a0, 1'b1, 1'b1)});
        end
        @(negedge sys_clk);
        req_valid = 0;
        repeat (3) @(negedge sys_clk);
        stop_test();
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 1000) begin
            n_errors++;
            stop_test();
        end
        if (q.size() > 0) begin
            #1 e = q.pop_front();
            `CHK("master0", seen0, e[40:0])
            `CHK("master1", seen1, e[81:41])
        end
    end
endmodule // tb_secure_alias_address_decoder
`default_nettype wire
